// >>> vpd_event_dma.sv
// DMA event generation, FIFO access and port registers
`timescale 1ns/10ps
// Function
// RL1: Capture raises event when level crosses threshold
// RL2: One capture request outstanding unless level exceeds double
// RL3: Outgoing counter loads threshold, counts reads down
// RL4: Luma and two chroma FIFOs tracked independently
// RL5: Chroma capture threshold is luma half rounded up
// RL6: Capture event counter picks field threshold
// RL7: Field boundary uses summed, then doubled, thresholds
// RL8: Display raises event when free space reaches threshold
// RL9: Display waits first write; double space allows another
// RL10: Incoming counter loads threshold, chroma half, counts writes
// RL11: Display event counter per field stops at zero
// RL12: No display events after field's last request
// RL13: FIFO accesses are whole 64-bit double words
// RL14: Software picks line length fitting halved chroma threshold
// RL15: Capture serves reads only; writes discarded, acknowledged
// RL16: Display serves writes only; reads acknowledged, arbitrary
// RL17: Inactive port acknowledges accesses without acting
// RL18: Active port performs every access on the FIFO
// RL19: Software waits 64 cycles after enabling port
// RL20: Channel reset clears that channel's event state; code clears it only while display_mode selects that channel
module vpd_event_dma
    import vpd_pkg::*;
#(
    parameter int TW = vpd_pkg::VPD_THR_WIDTH,
    parameter int EW = vpd_pkg::VPD_EVT_WIDTH
) (
    input  wire logic                                    clock,
    input  wire logic                                    nrst,
    // Register port
    input  wire logic                                    cfg_write,
    input  wire logic                                    cfg_read,
    input  wire logic [vpd_pkg::VPD_ADDR_WIDTH-1:0]      cfg_addr,
    input  wire logic [vpd_pkg::VPD_REG_WIDTH-1:0]       cfg_wdata,
    output logic      [vpd_pkg::VPD_REG_WIDTH-1:0]       cfg_rdata,
    input  wire logic [vpd_pkg::VPD_REG_WIDTH-1:0]       int_flag_set,
    output logic      [vpd_pkg::VPD_REG_WIDTH-1:0]       interrupt_enable,
    output logic                                         port_halt,
    output logic                                         display_mode,
    output logic                                         transport_stream_mode,
    output logic                                         display_channel_select,
    output logic      [vpd_pkg::VPD_CTL_POL_WIDTH-1:0]   pin_polarity,
    // Channel controls
    input  wire logic                                    peripheral_enable,
    input  wire logic                                    capture_channel_enable,
    input  wire logic                                    display_channel_enable,
    input  wire logic                                    capture_channel_reset,
    input  wire logic                                    display_channel_reset,
    input  wire logic [TW-1:0]                           field_one_threshold,
    input  wire logic [TW-1:0]                           field_two_threshold,
    input  wire logic [EW-1:0]                           capture_event_count_one,
    input  wire logic [EW-1:0]                           capture_event_count_two,
    input  wire logic [TW-1:0]                           display_threshold,
    input  wire logic [EW-1:0]                           field_one_event_count,
    input  wire logic [EW-1:0]                           field_two_event_count,
    input  wire logic                                    display_field_start,
    input  wire logic                                    display_field_two,
    // FIFO levels, one TW-bit slice per component
    input  wire logic [vpd_pkg::VPD_NUM_COMP*TW-1:0]     capture_level,
    input  wire logic [vpd_pkg::VPD_NUM_COMP*TW-1:0]     display_free,
    // DMA events
    output logic      [vpd_pkg::VPD_NUM_COMP-1:0]        dma_event,
    // DMA access port
    input  wire logic                                    dma_read,
    input  wire logic                                    dma_write,
    input  wire logic [vpd_pkg::VPD_COMP_WIDTH-1:0]      dma_comp,
    input  wire logic [vpd_pkg::VPD_WORD_WIDTH-1:0]      dma_wdata,
    output logic                                         dma_ready,
    output logic      [vpd_pkg::VPD_WORD_WIDTH-1:0]      dma_rdata,
    output logic                                         dma_rvalid,
    // Capture FIFO read side
    output logic      [vpd_pkg::VPD_NUM_COMP-1:0]        capture_fifo_read,
    input  wire logic [vpd_pkg::VPD_WORD_WIDTH-1:0]      capture_fifo_rdata,
    // Display FIFO write side
    output logic                                         display_fifo_valid,
    input  wire logic                                    display_fifo_ready,
    output logic      [vpd_pkg::VPD_COMP_WIDTH-1:0]      display_fifo_comp,
    output logic      [vpd_pkg::VPD_WORD_WIDTH-1:0]      display_fifo_wdata
);
    import vpd_pkg::*;

    localparam int NC = VPD_NUM_COMP;
    localparam int BW = VPD_COMP_WIDTH + VPD_WORD_WIDTH;

    // Port control state
    logic                         soft_reset;
    logic [7:0]                   ctl_low;
    logic [VPD_REG_WIDTH-1:0]     int_status;
    logic [NC-1:0]                pending;
    logic [NC-1:0]                busy;
    logic [NC-1:0]                raise;
    logic [NC-1:0]                comp_hit;
    logic                         buf_in_ready;
    logic                         buf_full;
    logic [BW-1:0]                buf_out;

    // Register decode, live only when enabled
    wire        reg_ok    = peripheral_enable;
    wire        wr_ctl    = reg_ok && cfg_write && cfg_addr == VPD_PORT_CONTROL;
    wire        wr_ie     = reg_ok && cfg_write && cfg_addr == VPD_INT_ENABLE;
    wire        wr_is     = reg_ok && cfg_write && cfg_addr == VPD_INT_STATUS;
    wire [31:0] is_clear  = wr_is ? cfg_wdata : VPD_ZERO_WORD;
    wire [31:0] ctl_word  = {16'h0000, soft_reset, port_halt, 6'h00, ctl_low};

    // Mode fields from control
    assign display_mode           = ctl_low[VPD_CTL_DISP_BIT];
    assign transport_stream_mode  = ctl_low[VPD_CTL_TSI_BIT];
    assign display_channel_select = ctl_low[VPD_CTL_DCHNL_BIT];
    assign pin_polarity = ctl_low[VPD_CTL_POL_LSB +: VPD_CTL_POL_WIDTH];

    // Run qualifiers; otherwise accesses only acknowledge
    wire port_live   = peripheral_enable && !port_halt && !soft_reset;
    wire capture_run = port_live && !display_mode && capture_channel_enable
                       && !capture_channel_reset;                    // RL17
    wire display_run = port_live && display_mode && display_channel_enable
                       && !display_channel_reset;                    // RL17
    wire cap_clear   = soft_reset || (!display_mode && capture_channel_reset);
    wire disp_clear  = soft_reset || (display_mode && display_channel_reset);
    wire comp_clear  = cap_clear || disp_clear;                      // RL20
    wire [31:0] stat_word = {23'h000000, buf_full, display_run, capture_run,
                             busy, pending};
    wire [31:0] rd_word   = !reg_ok ? VPD_ZERO_WORD :
                            cfg_addr == VPD_PORT_CONTROL ? ctl_word :
                            cfg_addr == VPD_PORT_STATUS  ? stat_word :
                            cfg_addr == VPD_INT_ENABLE   ? interrupt_enable :
                            cfg_addr == VPD_INT_STATUS   ? int_status :
                            VPD_ZERO_WORD;

    // Access qualification
    wire do_read  = dma_read && capture_run;                     // RL15 RL18
    wire do_write = dma_write && display_run;                    // RL16 RL18
    wire wr_taken = do_write && buf_in_ready;
    assign dma_ready = !do_write || buf_in_ready;                // RL17

    // Control: reset bit sets, halt bit clears, on a one
    // Mode bits only move while halted, so a running port cannot be upset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            soft_reset <= 1'b0;
            port_halt  <= 1'b1;
            ctl_low    <= VPD_CTL_LOW_RESET;
        end else if (soft_reset) begin
            soft_reset <= 1'b0;
            port_halt  <= 1'b1;
            ctl_low    <= VPD_CTL_LOW_RESET;
        end else if (wr_ctl) begin
            soft_reset <= cfg_wdata[VPD_CTL_RESET_BIT];
            if (cfg_wdata[VPD_CTL_HALT_BIT]) begin
                port_halt <= 1'b0;
            end
            if (port_halt) begin
                ctl_low <= cfg_wdata[7:0] & VPD_CTL_LOW_MASK;
            end
        end
    end

    // Interrupt enable and status; a new flag beats a same-cycle clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            interrupt_enable <= VPD_ZERO_WORD;
            int_status       <= VPD_ZERO_WORD;
        end else if (soft_reset) begin
            interrupt_enable <= VPD_ZERO_WORD;
            int_status       <= VPD_ZERO_WORD;
        end else begin
            if (wr_ie) begin
                interrupt_enable <= cfg_wdata;
            end
            int_status <= (int_status & ~is_clear) | int_flag_set;
        end
    end

    // Read data registered, one cycle late
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg_rdata <= VPD_ZERO_WORD;
        end else if (cfg_read) begin
            cfg_rdata <= rd_word;
        end
    end

    // Refused reads return filler
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dma_rdata  <= VPD_FILLER_WORD;
            dma_rvalid <= 1'b0;
        end else begin
            dma_rvalid <= dma_read;
            dma_rdata  <= do_read ? capture_fifo_rdata
                                  : VPD_FILLER_WORD;             // RL16 RL13
        end
    end

    // Display words pass an elastic buffer; a full buffer stalls the DMA
    vpd_fifo #(
        .WIDTH (BW),
        .DEPTH (VPD_BUF_DEPTH)
    ) u_write_buffer (
        .clock     (clock),
        .nrst      (nrst),
        .flush     (disp_clear),
        .in_valid  (do_write),
        .in_ready  (buf_in_ready),
        .in_data   ({dma_comp, dma_wdata}),                      // RL13
        .out_valid (display_fifo_valid),
        .out_ready (display_fifo_ready),
        .out_data  (buf_out),
        .full      (buf_full)
    );
    assign display_fifo_comp  = buf_out[BW-1 -: VPD_COMP_WIDTH];
    assign display_fifo_wdata = buf_out[VPD_WORD_WIDTH-1:0];

    // Per-component event engine
    generate
        for (genvar c = 0; c < NC; c++) begin : g_comp        // RL4
            logic          gen_fld;
            logic          svc_fld;
            logic [EW-1:0] gen_cnt;
            logic [EW-1:0] svc_cnt;
            logic [TW-1:0] word_cnt;
            logic [EW-1:0] disp_evt;
            logic          pend;
            wire           chroma = (c != VPD_COMP_LUMA);
            wire [TW-1:0]  level  = capture_level[c*TW +: TW];
            wire [TW-1:0]  free   = display_free[c*TW +: TW];

            // Chroma capture halves round up to a whole double word; the display half rounds down
            wire [TW-1:0] half1 = TW'(field_one_threshold[TW-1:1])
                                  + TW'(field_one_threshold[0]);  // RL5
            wire [TW-1:0] half2 = TW'(field_two_threshold[TW-1:1])
                                  + TW'(field_two_threshold[0]);  // RL5
            wire [TW-1:0] thr1  = chroma ? half1 : field_one_threshold;
            wire [TW-1:0] thr2  = chroma ? half2 : field_two_threshold;
            wire [TW-1:0] thr_gen = gen_fld ? thr2 : thr1;        // RL6
            wire [TW-1:0] thr_svc = svc_fld ? thr2 : thr1;        // RL6
            wire [EW-1:0] cnt_gen = gen_fld ? capture_event_count_two
                                            : capture_event_count_one;
            wire [EW-1:0] cnt_svc = svc_fld ? capture_event_count_two
                                            : capture_event_count_one;
            wire [TW-1:0] dthr  = chroma ? display_threshold >> 1
                                         : display_threshold;     // RL10

            // While a service runs, the next event needs room for both
            // services: twice one field, or the sum across fields
            wire          run_on   = (word_cnt != '0);
            wire [TW:0]   cap_sum  = {1'b0, thr_svc} + {1'b0, thr_gen};
            wire          cap_fire = run_on ? ({1'b0, level} > cap_sum)
                                            : (level >= thr_gen); // RL7 RL2
            wire          cap_raise = capture_run && !pend && thr_gen != '0
                                      && cap_fire;                // RL1
            wire [TW:0]   disp_need = run_on ? {dthr, 1'b0}
                                             : {1'b0, dthr};      // RL9
            wire          disp_raise = display_run && !pend && dthr != '0
                                       && disp_evt != '0          // RL12
                                       && {1'b0, free} >= disp_need; // RL8

            // Access of this component, and service start
            wire          access = comp_hit[c] && (do_read || wr_taken);
            wire          start  = access && !run_on;
            wire [TW-1:0] load   = display_mode ? dthr : thr_svc;
            wire [EW-1:0] gen_nx = gen_cnt + 1'b1;
            wire [EW-1:0] svc_nx = svc_cnt + 1'b1;

            assign comp_hit[c]    = (dma_comp == VPD_COMP_WIDTH'(c));
            assign raise[c]       = cap_raise || disp_raise;
            assign pending[c]     = pend;
            assign busy[c]        = run_on;
            assign capture_fifo_read[c] = do_read && comp_hit[c];  // RL18

            // Pending flag: raising beats a same-cycle service start
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    pend <= 1'b0;
                end else if (comp_clear) begin
                    pend <= 1'b0;                                 // RL20
                end else if (raise[c]) begin
                    pend <= 1'b1;
                end else if (start) begin
                    pend <= 1'b0;                                 // RL2 RL9
                end
            end

            // Word counter; the starting access already counts one word
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    word_cnt <= '0;
                end else if (comp_clear) begin
                    word_cnt <= '0;                               // RL20
                end else if (start) begin
                    word_cnt <= load - 1'b1;                      // RL3 RL10
                end else if (access) begin
                    word_cnt <= word_cnt - 1'b1;                  // RL3 RL10
                end
            end

            // Capture field tracking
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    gen_fld <= 1'b0;
                    gen_cnt <= '0;
                    svc_fld <= 1'b0;
                    svc_cnt <= '0;
                end else if (cap_clear) begin
                    gen_fld <= 1'b0;                              // RL20
                    gen_cnt <= '0;
                    svc_fld <= 1'b0;
                    svc_cnt <= '0;
                end else begin
                    if (cap_raise) begin
                        gen_fld <= (gen_nx >= cnt_gen) ^ gen_fld; // RL6
                        gen_cnt <= (gen_nx >= cnt_gen) ? '0 : gen_nx;
                    end
                    if (start && !display_mode) begin
                        svc_fld <= (svc_nx >= cnt_svc) ^ svc_fld; // RL7
                        svc_cnt <= (svc_nx >= cnt_svc) ? '0 : svc_nx;
                    end
                end
            end

            // Display budget reloads at field start
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    disp_evt <= '0;
                end else if (disp_clear) begin
                    disp_evt <= '0;                               // RL20
                end else if (display_field_start) begin
                    disp_evt <= display_field_two ? field_two_event_count
                                                  : field_one_event_count;
                end else if (disp_raise) begin
                    disp_evt <= disp_evt - 1'b1;                  // RL11
                end
            end
        end
    endgenerate

    // Registered one-cycle event pulses
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dma_event <= '0;
        end else begin
            dma_event <= raise;                                   // RL1 RL8
        end
    end
endmodule

// >>> vpd_pkg.sv
// Shared constants for the DMA event logic
package vpd_pkg;
    // Register offsets
    localparam int               VPD_ADDR_WIDTH      = 8;
    localparam logic [7:0]       VPD_PORT_CONTROL    = 8'hC0;
    localparam logic [7:0]       VPD_PORT_STATUS     = 8'hC4;
    localparam logic [7:0]       VPD_INT_ENABLE      = 8'hC8;
    localparam logic [7:0]       VPD_INT_STATUS      = 8'hCC;
    localparam int               VPD_REG_WIDTH       = 32;

    // Port control field positions and reset value
    localparam int               VPD_CTL_RESET_BIT   = 15;
    localparam int               VPD_CTL_HALT_BIT    = 14;
    localparam int               VPD_CTL_POL_LSB     = 4;
    localparam int               VPD_CTL_POL_WIDTH   = 4;
    localparam int               VPD_CTL_TSI_BIT     = 2;
    localparam int               VPD_CTL_DISP_BIT    = 1;
    localparam int               VPD_CTL_DCHNL_BIT   = 0;
    localparam logic [7:0]       VPD_CTL_LOW_MASK    = 8'hF7;
    localparam logic [7:0]       VPD_CTL_LOW_RESET   = 8'h00;
    localparam logic [31:0]      VPD_ZERO_WORD       = 32'h0000_0000;

    // Port status field positions
    localparam int               VPD_STAT_PEND_LSB   = 0;
    localparam int               VPD_STAT_BUSY_LSB   = 3;
    localparam int               VPD_STAT_CAP_RUN    = 6;
    localparam int               VPD_STAT_DISP_RUN   = 7;
    localparam int               VPD_STAT_BUF_FULL   = 8;

    // Data path
    localparam int               VPD_NUM_COMP        = 3;
    localparam int               VPD_COMP_WIDTH      = 2;
    localparam int               VPD_COMP_LUMA       = 0;
    localparam int               VPD_WORD_WIDTH      = 64;
    localparam int               VPD_BUF_DEPTH       = 8;
    localparam logic [63:0]      VPD_FILLER_WORD     = 64'h0000_0000_0000_0000;

    // Default widths
    localparam int               VPD_THR_WIDTH       = 16;
    localparam int               VPD_EVT_WIDTH       = 12;
endpackage

// >>> vpd_fifo.sv
// Synchronous FIFO, valid/ready on both sides
`timescale 1ns/10ps
module vpd_fifo #(
    parameter int WIDTH = 66,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  full
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push;
    wire              pop;
    wire [AW-1:0]     last_slot;

    // Handshake terms; a full buffer stalls the writer
    assign last_slot = AW'(DEPTH - 1);
    assign full      = (count == (AW+1)'(DEPTH));
    assign in_ready  = !full;
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    // Storage written on an accepted word
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at the depth, so DEPTH need not be a power of two
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == last_slot) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == last_slot) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> vpd_dma_model.sv
// DMA controller model
`timescale 1ns/10ps
module vpd_dma_model (
    input  wire logic   clock,
    input  wire logic   dma_ready,
    output logic        dma_read = 1'b0,
    output logic        dma_write = 1'b0,
    output logic [1:0]  dma_comp = 2'h0,
    output logic [63:0] dma_wdata = 64'h0
);
    // Holds each request until ready
    task burst(input logic wr, input logic [1:0] c, input int n);
        @(posedge clock);
        for (int i = 0; i < n; i++) begin
            dma_read <= !wr;
            dma_write <= wr;
            dma_comp <= c;
            dma_wdata <= {32'hD000_0000, 32'(i)};
            do @(negedge clock); while (dma_ready !== 1'b1);
            @(posedge clock);
        end
        dma_read <= 1'b0;
        dma_write <= 1'b0;
    endtask
endmodule

// >>> vpd_event_dma_props.sv
// DMA access port assertions
`timescale 1ns/10ps
module vpd_event_dma_props (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       peripheral_enable,
    input wire logic       capture_channel_enable,
    input wire logic       capture_channel_reset,
    input wire logic       port_halt,
    input wire logic       display_mode,
    input wire logic       dma_read,
    input wire logic       dma_write,
    input wire logic [1:0] dma_comp,
    input wire logic       dma_ready,
    input wire logic       dma_rvalid,
    input wire logic [2:0] capture_fifo_read
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Capture side not running
    wire idle = port_halt || !peripheral_enable || !capture_channel_enable
        || capture_channel_reset;
    property p_rv; dma_read |=> dma_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("no rvalid");
    property p_rvc; dma_rvalid |-> $past(dma_read); endproperty
    a_rvc: assert property (p_rvc) else $error("stray rvalid");
    property p_rdy; dma_read |-> dma_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("read stalled");
    property p_low; !dma_ready |-> dma_write && display_mode; endproperty
    a_low: assert property (p_low) else $error("bad stall");
    property p_dsp; display_mode |-> capture_fifo_read == 3'h0; endproperty
    a_dsp: assert property (p_dsp) else $error("display read");
    property p_idl;
        idle && dma_read |-> capture_fifo_read == 3'h0 ##1 dma_rvalid;
    endproperty
    a_idl: assert property (p_idl) else $error("idle acted");
    property p_act;
        dma_read && !idle && !display_mode && dma_comp != 2'h3
            |-> capture_fifo_read == 3'(1 << dma_comp);
    endproperty
    a_act: assert property (p_act) else $error("read lost");
    property p_cau; capture_fifo_read != 3'h0 |-> dma_read; endproperty
    a_cau: assert property (p_cau) else $error("fifo read");
endmodule
bind vpd_event_dma vpd_event_dma_props props_u (.*);

// >>> tb_vpd_event_dma.sv
// Bench for the DMA event logic
`timescale 1ns/10ps
module tb_vpd_event_dma;
    logic clock = 0, nrst = 0, peripheral_enable = 1, port_halt, display_mode;
    logic capture_channel_enable = 1, display_channel_enable = 1;
    logic cfg_write, cfg_read, transport_stream_mode, display_channel_select;
    logic capture_channel_reset, display_channel_reset, display_field_start;
    logic display_field_two, display_fifo_ready, dma_ready, dma_rvalid;
    logic dma_read, dma_write, display_fifo_valid;
    logic [7:0] cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, int_flag_set, interrupt_enable, rd;
    logic [3:0] pin_polarity;
    logic [15:0] field_one_threshold = 16'h5, field_two_threshold = 16'h5;
    logic [15:0] display_threshold = 16'h4;
    logic [11:0] capture_event_count_one = 12'h2;
    logic [11:0] capture_event_count_two = 12'h2;
    logic [11:0] field_one_event_count = 12'h1, field_two_event_count = 12'h1;
    logic [47:0] capture_level, display_free;
    logic [2:0] dma_event, capture_fifo_read, seen = 3'h0;
    logic [1:0] dma_comp, display_fifo_comp;
    logic [63:0] dma_wdata, dma_rdata, display_fifo_wdata;
    logic [63:0] capture_fifo_rdata = 64'hCAFE_0000_1234_5678;
    int errors = 0, comparisons = 0, cyc = 0, pops = 0;
    vpd_event_dma dut_u (.*);
    vpd_dma_model dma_u (.*);
    initial forever #50 clock = ~clock;
    task chk(input string n, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task reg_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock) {cfg_write, cfg_read} <= {w, !w};
        {cfg_addr, cfg_wdata} <= {a, d};
        @(posedge clock) {cfg_write, cfg_read} <= 2'b00;
        @(negedge clock) rd = cfg_rdata;
    endtask
    // Events seen over n cycles
    task evs(input int n, input logic [2:0] e);
        @(negedge clock) seen = 3'h0;
        repeat (n) @(posedge clock);
        @(negedge clock) chk("dma_event", e, seen);
    endtask
    task rd1(input logic [63:0] e);
        dma_u.burst(1'b0, 2'd0, 1);
        @(negedge clock) chk("dma_rdata", e, dma_rdata);
    endtask
    task stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Monitor and cycle ceiling
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (dma_event != 3'h0) seen <= seen | dma_event;
        if (display_fifo_valid && display_fifo_ready) pops <= pops + 1;
        if (cyc == 3000) begin
            errors++;
            stop_test;
        end
    end
    initial begin
        {cfg_write, cfg_read, cfg_addr, cfg_wdata, int_flag_set} = '0;
        {capture_channel_reset, display_channel_reset, display_field_start,
         display_field_two, display_fifo_ready, capture_level, display_free} = '0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        reg_acc(1'b0, 8'hC0, 32'h0);
        chk("port_control", 64'h4000, rd);
        reg_acc(1'b0, 8'hD0, 32'h0);
        chk("unmapped", 64'h0, rd);
        reg_acc(1'b1, 8'hC8, 32'h0000_00F0);
        chk("int_enable", 64'hF0, interrupt_enable);
        reg_acc(1'b1, 8'hC0, 32'h0000_4000);
        chk("halt", 64'h0, port_halt);
        @(posedge clock) peripheral_enable <= 1'b0;
        rd1(64'h0);
        @(posedge clock) peripheral_enable <= 1'b1;
        capture_level <= 48'h0003_0002_0005;
        evs(6, 3'b101);
        evs(6, 3'b000);
        @(posedge clock) capture_channel_reset <= 1'b1;
        @(posedge clock) capture_channel_reset <= 1'b0;
        evs(6, 3'b101);
        dma_u.burst(1'b1, 2'd0, 1);
        dma_u.burst(1'b0, 2'd0, 4);
        evs(4, 3'b000);
        rd1(capture_fifo_rdata);
        evs(6, 3'b001);
        $display("test capture done");
        reg_acc(1'b1, 8'hC0, 32'h0000_8000);
        reg_acc(1'b1, 8'hC0, 32'h0000_4002);
        @(posedge clock) capture_level <= 48'h0;
        display_free <= {3{16'h0004}};
        evs(4, 3'b000);
        @(posedge clock) display_field_start <= 1'b1;
        @(posedge clock) display_field_start <= 1'b0;
        evs(6, 3'b111);
        dma_u.burst(1'b1, 2'd0, 4);
        evs(6, 3'b000);
        chk("fifo_word", 64'hD000_0000_0000_0000, display_fifo_wdata);
        fork
            dma_u.burst(1'b1, 2'd0, 5);
            begin
                repeat (12) @(posedge clock);
                @(negedge clock) chk("dma_ready", 64'h0, dma_ready);
                @(posedge clock) display_fifo_ready <= 1'b1;
            end
        join
        repeat (12) @(posedge clock);
        chk("drained", 64'h9, pops);
        rd1(64'h0);
        $display("test display done");
        stop_test;
    end
endmodule
